// ==== rtl/fgr_refresh_ctrl.sv ====
// Refresh granularity control of the memory device with APB registers.
`timescale 1ns/10ps
`include "fgr_params.svh"
module fgr_refresh_ctrl
    import fgr_pkg::*;
#(
    parameter int CNTW = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command pins from the controller; synchronised below.
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_group_bit0,
    input wire logic self_refresh_entry,
    input wire logic self_refresh_exit,
    // Status outputs.
    output logic [1:0] active_rate,
    output logic refresh_busy,
    output logic [15:0] avg_refresh_interval,
    output logic [7:0] refresh_cycle_time
);
    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    // Pins cross from the command clock tree; two flops each.
    // The controller holds a pattern for two clocks, so at least one
    // clean sample of the whole word reaches the decoder.
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= 8'h1f;
            pin_s2_reg <= 8'h1f;
        end else begin
            pin_s1_reg <= {self_refresh_exit, self_refresh_entry,
                bank_group_bit0, we_n, cas_n, ras_n, act_n, cs_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    // Previous sample to turn the level into a one-cycle command.
    logic [7:0] pin_d_reg;
    // Resets to the idle pattern so that no false edge follows reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_d_reg <= 8'h1f;
        end else begin
            pin_d_reg <= pin_s2_reg;
        end
    end
    // Refresh is chip select low, act high, ras cas low, we high.
    // Only the first cycle of a held pattern counts as a command, so a
    // pattern held for several clocks starts one refresh, not several.
    // Self refresh entry and exit are rising edges of their levels.
    logic ref_lvl;
    logic ref_cmd;
    logic sr_entry;
    logic sr_exit;
    assign ref_lvl = (pin_s2_reg[4:0] == 5'b10010);
    assign ref_cmd = ref_lvl && (pin_d_reg[4:0] != 5'b10010);
    assign sr_entry = pin_s2_reg[6] && !pin_d_reg[6];
    assign sr_exit = pin_s2_reg[7] && !pin_d_reg[7];

    // ****************************************************************
    // Mode register and APB decode.
    // ****************************************************************
    // The granularity field and the temperature refresh enable share
    // one word; each has its own byte strobe so software can change one
    // without the other.
    logic [2:0] mode_reg;
    logic tcr_en_reg;
    logic mode_wr;
    logic tcr_wr;
    logic [2:0] wmode;
    logic wmode_ok;
    logic wr_acc;
    // A write takes effect in the access cycle only.
    assign wr_acc = psel && penable && pwrite;
    assign wmode = pwdata[`FGR_MODE_LSB+2:`FGR_MODE_LSB];
    // Reserved codes and non-single codes under temperature refresh
    // are refused with an error rather than stored.
    always_comb begin
        case (wmode)
            3'b000: wmode_ok = 1'b1;
            3'b001, 3'b010, 3'b101, 3'b110: wmode_ok = !tcr_en_reg;
            default: wmode_ok = 1'b0;
        endcase
    end
    // A refused code leaves the field untouched; the error answer was
    // already prepared in the setup cycle from the same check.
    assign mode_wr = wr_acc && (paddr == `FGR_OFF_MODE) && pstrb[0]
        && wmode_ok;
    assign tcr_wr = wr_acc && (paddr == `FGR_OFF_MODE) && pstrb[1];
    // Granularity field: fixed single after reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= `FGR_MODE_RST;
        end else if (mode_wr) begin
            mode_reg <= wmode;
        end
    end
    // Temperature refresh enable only with fixed single in force.
    // Enabling it while a write in the same cycle asks for another mode
    // is refused as well, so the pair can never be left inconsistent.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tcr_en_reg <= 1'b0;
        end else if (tcr_wr && (!pwdata[8] || (mode_reg == 3'b000)
                && !(pstrb[0] && wmode != 3'b000))) begin
            tcr_en_reg <= pwdata[8];
        end
    end

    // ****************************************************************
    // Rate in force.
    // ****************************************************************
    // The rate changes on a mode write or on a refresh command; a mode
    // write wins when both fall in one cycle, since software has asked
    // for a new configuration that the command must already obey.
    fgr_rate_e rate_reg;
    fgr_rate_e rate_next;
    fgr_rate_e high_rate;
    // Higher rate of the mode pair, from the low field bits.
    assign high_rate = (mode_reg[1:0] == 2'b10) ? FGR_RATE_4X
        : (mode_reg[1:0] == 2'b01) ? FGR_RATE_2X : FGR_RATE_1X;
    // Next rate: held unless a mode write or a refresh picks a new one.
    always_comb begin
        rate_next = rate_reg;
        if (mode_wr) begin
            // Same rate in fixed or per-command form is no change.
            rate_next = (wmode[2]) ? FGR_RATE_1X
                : (wmode[1] ? FGR_RATE_4X
                : (wmode[0] ? FGR_RATE_2X : FGR_RATE_1X));
            if (wmode[2] && rate_reg != FGR_RATE_1X
                    && rate_reg == ((wmode[1]) ? FGR_RATE_4X : FGR_RATE_2X))
                rate_next = rate_reg;
        end else if (ref_cmd) begin
            if (mode_reg[2]) begin
                // Per-command pick from bank group bit zero.
                rate_next = bank_pick() ? high_rate : FGR_RATE_1X;
            end else begin
                rate_next = high_rate;
            end
        end
    end
    // The select bit travels through the same synchroniser as the pattern.
    function automatic logic bank_pick();
        bank_pick = pin_s2_reg[5];
    endfunction
    // Rate register; single rate after reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_reg <= FGR_RATE_1X;
        end else begin
            rate_reg <= rate_next;
        end
    end

    // ****************************************************************
    // Timing that applies to the current rate.
    // ****************************************************************
    // Cycle counts are rounded up from the nanosecond figures, so the
    // reported times are never shorter than the minimum the rate needs.
    // Hot-case shortening of the interval is left to the controller.
    logic [15:0] refi_cyc;
    logic [7:0] rfc_cyc;
    // Decoded from the next rate so the outputs move with the change.
    always_comb begin
        case (rate_next)
            FGR_RATE_2X: begin
                refi_cyc = 16'(`FGR_CYC(`FGR_REFI_BASE_NS) / 2);
                rfc_cyc = 8'(`FGR_CYC(`FGR_RFC2_NS));
            end
            FGR_RATE_4X: begin
                refi_cyc = 16'(`FGR_CYC(`FGR_REFI_BASE_NS) / 4);
                rfc_cyc = 8'(`FGR_CYC(`FGR_RFC4_NS));
            end
            default: begin
                refi_cyc = 16'(`FGR_CYC(`FGR_REFI_BASE_NS));
                rfc_cyc = 8'(`FGR_CYC(`FGR_RFC1_NS));
            end
        endcase
    end
    // Busy window started by each refresh, sized by its own rate.
    logic busy;
    logic [7:0] remain;
    // A new refresh reloads the timer; the controller must not issue one
    // early, and the device does not refuse it if it does.
    fgr_busy_timer #(
        .W(8)
    ) u_busy (
        .clk(clk),
        .rst_b(rst_b),
        .load(ref_cmd),
        .load_val(rfc_cyc),
        .busy(busy),
        .remain(remain)
    );
    // Timing outputs follow the rate from the changing command on.
    // Busy is raised in the command cycle itself to hide the timer load.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avg_refresh_interval <= 16'(`FGR_CYC(`FGR_REFI_BASE_NS));
            refresh_cycle_time <= 8'(`FGR_CYC(`FGR_RFC1_NS));
            active_rate <= 2'h0;
            refresh_busy <= 1'b0;
        end else begin
            avg_refresh_interval <= refi_cyc;
            refresh_cycle_time <= rfc_cyc;
            active_rate <= rate_next;
            refresh_busy <= busy || ref_cmd;
        end
    end

    // ****************************************************************
    // Higher-rate refresh count for software to inspect.
    // ****************************************************************
    // Counts are only reported; the device never refuses a refresh
    // or self refresh entry, the controller keeps the count rules.
    logic [CNTW-1:0] hi_cnt_reg;
    logic sr_active_reg;
    // Cleared by a mode write, a self refresh exit or a single-rate
    // refresh, which are the points from which the pair rules count.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt_reg <= '0;
        end else if (mode_wr || sr_exit) begin
            hi_cnt_reg <= '0;
        end else if (ref_cmd) begin
            if (rate_next == FGR_RATE_1X)
                hi_cnt_reg <= '0;
            else
                hi_cnt_reg <= hi_cnt_reg + 1'b1;
        end
    end
    // Self refresh accepted unconditionally in every mode.
    // An uneven count at entry is for the controller to make up after
    // exit; the device only reports it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_active_reg <= 1'b0;
        end else if (sr_entry) begin
            sr_active_reg <= 1'b1;
        end else if (sr_exit) begin
            sr_active_reg <= 1'b0;
        end
    end
    // Count is not aligned when the pair rule is not met.
    // Quad modes need a multiple of four, double modes an even count.
    logic misaligned;
    assign misaligned = (rate_reg == FGR_RATE_4X || mode_reg[1])
        ? (hi_cnt_reg[1:0] != 2'b00) : hi_cnt_reg[0];

    // ****************************************************************
    // APB read and answer, zero wait states.
    // ****************************************************************
    // Every access gets one wait-free answer: ready is raised in the
    // access cycle, whatever the address, and an unmapped one errors.
    logic acc;
    logic hit;
    assign acc = psel && !penable;
    // Only the four word offsets decode; the rest give an error.
    assign hit = (paddr == `FGR_OFF_MODE) || (paddr == `FGR_OFF_STATUS)
        || (paddr == `FGR_OFF_TIMING) || (paddr == `FGR_OFF_COUNT);
    // Read data and ready are registered in the setup cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc && (!hit || (pwrite && paddr == `FGR_OFF_MODE
                && pstrb[0] && !wmode_ok));
            // Cleared every cycle so stale data never stands on the bus.
            prdata <= 32'h0;
            if (acc && !pwrite) begin
                case (paddr)
                    `FGR_OFF_MODE: prdata <= {22'h0, tcr_en_reg,
                        mode_reg, 6'h0};
                    `FGR_OFF_STATUS: prdata <= {24'h0, remain[3:0],
                        misaligned, sr_active_reg, rate_reg};
                    `FGR_OFF_TIMING: prdata <= {8'h0, refresh_cycle_time,
                        avg_refresh_interval};
                    `FGR_OFF_COUNT: prdata <= {{(32-CNTW){1'b0}},
                        hi_cnt_reg};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// ==== rtl/fgr_params.svh ====
// Constants for the refresh granularity block: offsets, fields and timing.
`ifndef FGR_PARAMS_SVH
`define FGR_PARAMS_SVH
// ****************************************************************
// Register map.
// ****************************************************************
`define FGR_OFF_MODE 12'h000
`define FGR_OFF_STATUS 12'h004
`define FGR_OFF_TIMING 12'h008
`define FGR_OFF_COUNT 12'h00c
// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define FGR_MODE_LSB 6
`define FGR_MODE_RST 3'h0
// ****************************************************************
// Timing in its own units and derived cycle counts at 200 MHz.
// ****************************************************************
`define FGR_CLK_MHZ 200
`define FGR_REFI_BASE_NS 7800
`define FGR_RFC1_NS 260
`define FGR_RFC2_NS 160
`define FGR_RFC4_NS 110
`define FGR_CYC(ns) (((ns) * `FGR_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/fgr_pkg.sv ====
// Types shared by the refresh granularity block.
package fgr_pkg;
    // Decoded refresh granularity mode.
    typedef enum logic [2:0] {
        FGR_FIXED_1X = 3'b000,
        FGR_FIXED_2X = 3'b001,
        FGR_FIXED_4X = 3'b010,
        FGR_OTF_12 = 3'b101,
        FGR_OTF_14 = 3'b110
    } fgr_mode_e;
    // Rate of the refresh currently in force.
    typedef enum logic [1:0] {
        FGR_RATE_1X = 2'b00,
        FGR_RATE_2X = 2'b01,
        FGR_RATE_4X = 2'b10
    } fgr_rate_e;
endpackage

// ==== rtl/fgr_busy_timer.sv ====
// Down counter that holds the refresh cycle busy window.
`timescale 1ns/10ps
module fgr_busy_timer #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Load request and value.
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Busy status.
    output logic busy,
    output logic [W-1:0] remain
);
    // Count down to zero; a new load always restarts the window.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remain <= '0;
        end else if (load) begin
            remain <= load_val;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end
    // Busy while any cycles remain.
    assign busy = (remain != '0);
endmodule

// ==== dv/fgr_refresh_monitor.sv ====
// Checker of the refresh granularity block's ports.
`timescale 1ns/10ps
module fgr_refresh_monitor
    import fgr_pkg::*;
(
    // Clock, reset and APB answer.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Command pins and status.
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic [1:0] active_rate,
    input wire logic refresh_busy,
    input wire logic [15:0] avg_refresh_interval,
    input wire logic [7:0] refresh_cycle_time
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // A refresh starts in the first cycle that shows the pattern.
    sequence s_ref;
        (cs_n || ras_n || cas_n) ##1 !(cs_n || ras_n || cas_n);
    endsequence
    a_setup_answer:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready held");
    a_error_ready:
        assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rate_legal:
        assert property (active_rate != 2'h3)
        else $error("reserved rate");
    a_busy_start:
        assert property (s_ref |-> ##[2:4] refresh_busy)
        else $error("refresh not started");
    a_busy_hold:
        assert property ($rose(refresh_busy) |-> refresh_busy[*8])
        else $error("busy too short");
    a_busy_ends:
        assert property ($rose(refresh_busy) |-> ##[20:56] !refresh_busy)
        else $error("busy too long");
    a_single_time:
        assert property (active_rate == FGR_RATE_1X |->
            avg_refresh_interval == 16'h0618 && refresh_cycle_time == 8'h34)
        else $error("single timing");
    a_double_time:
        assert property (active_rate == FGR_RATE_2X |->
            avg_refresh_interval == 16'h030c && refresh_cycle_time == 8'h20)
        else $error("double timing");
    a_quad_time:
        assert property (active_rate == FGR_RATE_4X |->
            avg_refresh_interval == 16'h0186 && refresh_cycle_time == 8'h16)
        else $error("quad timing");
endmodule
bind fgr_refresh_ctrl fgr_refresh_monitor fgr_refresh_monitor_inst (.clk,
    .rst_b, .psel, .penable, .pready, .pslverr, .cs_n, .ras_n, .cas_n,
    .active_rate, .refresh_busy, .avg_refresh_interval, .refresh_cycle_time);

// ==== dv/fgr_ctrl_model.sv ====
// Controller model that issues refresh commands on the pins.
`timescale 1ns/10ps
module fgr_ctrl_model (
    // Clock and device status.
    input wire logic clk,
    input wire logic refresh_busy,
    // Command pins.
    output logic cs_n,
    output logic act_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_group_bit0
);
    logic cmd = 1'b0; // High while the refresh pattern is driven.
    assign cs_n = ~cmd;
    assign act_n = 1'b1;
    assign ras_n = ~cmd;
    assign cas_n = ~cmd;
    assign we_n = 1'b1;
    initial bank_group_bit0 = 1'b0;
    // Sends n refreshes, each later one spaced out more slowly.
    task automatic refresh(input logic bg, input int n, output logic ok);
        int i;
        int m;
        logic seen;
        ok = 1'b1;
        for (m = 0; m < n; m++) begin
            repeat (m) @(posedge clk);
            cmd <= 1'b1;
            bank_group_bit0 <= bg;
            repeat (2) @(posedge clk);
            cmd <= 1'b0;
            // A released line must not keep looking valid.
            bank_group_bit0 <= ~bg;
            seen = 1'b0;
            // Nothing new is sent until the cycle time has run out.
            for (i = 0; i < 100 && !(seen && !refresh_busy); i++) begin
                @(posedge clk);
                seen = seen | refresh_busy;
            end
            ok = ok & seen & !refresh_busy;
        end
    endtask
endmodule

// ==== dv/fgr_refresh_ctrl_tb.sv ====
// Self-checking bench of the refresh granularity block.
`timescale 1ns/10ps
module fgr_refresh_ctrl_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ok, refresh_busy;
    logic cs_n, act_n, ras_n, cas_n, we_n, bank_group_bit0;
    logic self_refresh_entry = 1'b0;
    logic self_refresh_exit = 1'b0;
    logic [1:0] active_rate;
    logic [15:0] avg_refresh_interval;
    logic [7:0] refresh_cycle_time;
    int fails = 0;
    int compares = 0;
    int j;
    // Row: mode, select bit, rate, {cycle, interval}, refresh count.
    typedef struct packed {logic [2:0] code; logic bg; logic [1:0] rate;
        logic [23:0] tim; logic [2:0] n;} fgr_row_s;
    fgr_row_s rows [7] = '{
        '{3'h0, 1'b1, 2'h0, 24'h340618, 3'h1},
        '{3'h1, 1'b0, 2'h1, 24'h20030c, 3'h2},
        '{3'h2, 1'b0, 2'h2, 24'h160186, 3'h4},
        '{3'h5, 1'b0, 2'h0, 24'h340618, 3'h1},
        '{3'h5, 1'b1, 2'h1, 24'h20030c, 3'h2},
        '{3'h6, 1'b1, 2'h2, 24'h160186, 3'h4},
        '{3'h6, 1'b0, 2'h0, 24'h340618, 3'h1}};
    logic [2:0] bad [3] = '{3'h3, 3'h4, 3'h7};
    always #2.5 clk = ~clk;
    fgr_refresh_ctrl fgr_refresh_ctrl_inst (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cs_n,
        .act_n, .ras_n, .cas_n, .we_n, .bank_group_bit0, .self_refresh_entry,
        .self_refresh_exit, .active_rate, .refresh_busy,
        .avg_refresh_interval, .refresh_cycle_time);
    fgr_ctrl_model fgr_ctrl_model_inst (.clk, .refresh_busy, .cs_n, .act_n,
        .ras_n, .cas_n, .we_n, .bank_group_bit0);
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request stands until ready is sampled.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            fails++;
            end_of_test();
        end
        @(posedge clk);
    endtask
    task automatic refs(input logic bg, input int n);
        fgr_ctrl_model_inst.refresh(bg, n, ok);
        chk("refresh done", 32'h1, {31'h0, ok});
        if (!ok) begin
            end_of_test();
        end
    endtask
    // Holds self refresh for a while, checks status, then exits.
    task automatic self_ref();
        self_refresh_entry <= 1'b1;
        // Six edges cover the three-edge pin pipeline.
        repeat (6) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        chk("in self refresh", 32'h4, rd & 32'h4);
        chk("misaligned", 32'h8, rd & 32'h8);
        self_refresh_entry <= 1'b0;
        self_refresh_exit <= 1'b1;
        repeat (6) @(posedge clk);
        self_refresh_exit <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (j = 0; j < 7; j++) begin
            apb(1'b1, 12'h000, {23'h0, rows[j].code, 6'h0}, 4'h1);
            apb(1'b0, 12'h000, 32'h0, 4'h0);
            chk("mode", {23'h0, rows[j].code, 6'h0}, rd);
            refs(rows[j].bg, rows[j].n);
            chk("rate", {30'h0, rows[j].rate}, {30'h0, active_rate});
            apb(1'b0, 12'h008, 32'h0, 4'h0);
            chk("timing", {8'h0, rows[j].tim}, rd);
            chk("hot interval", 32'h0618 >> (rows[j].rate + 2'h1),
                {17'h0, rd[15:1]});
            apb(1'b0, 12'h00c, 32'h0, 4'h0);
            chk("count", {29'h0, rows[j].rate != 2'h0 ? rows[j].n : 3'h0},
                rd);
            apb(1'b0, 12'h004, 32'h0, 4'h0);
            chk("aligned", 32'h0, rd & 32'h8);
            $display("row %0d done", j);
        end
        // Reserved codes are refused and the mode stays as it was.
        for (j = 0; j < 3; j++) begin
            apb(1'b1, 12'h000, {23'h0, bad[j], 6'h0}, 4'h1);
            chk("reserved error", 32'h1, {31'h0, er});
            apb(1'b0, 12'h000, 32'h0, 4'h0);
            chk("kept mode", 32'h180, rd);
        end
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        // With temperature refresh on, only fixed single is taken.
        apb(1'b1, 12'h000, 32'h0, 4'h1);
        apb(1'b1, 12'h000, 32'h100, 4'h2);
        apb(1'b1, 12'h000, 32'h40, 4'h1);
        chk("tcr error", 32'h1, {31'h0, er});
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("tcr mode", 32'h200, rd);
        apb(1'b1, 12'h000, 32'h0, 4'h2);
        $display("refusal tests done");
        // Odd quad count, self refresh, then four extra quads on exit.
        apb(1'b1, 12'h000, 32'h80, 4'h1);
        refs(1'b1, 1);
        self_ref();
        refs(1'b1, 4);
        apb(1'b0, 12'h00c, 32'h0, 4'h0);
        chk("count after exit", 32'h4, rd);
        // Odd double count, self refresh, then two extra doubles on exit.
        apb(1'b1, 12'h000, 32'h40, 4'h1);
        refs(1'b0, 1);
        self_ref();
        refs(1'b0, 2);
        apb(1'b0, 12'h00c, 32'h0, 4'h0);
        chk("double extras", 32'h2, rd);
        $display("self refresh test done");
        // A reset in mid-run brings back the single-rate defaults.
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset timing", 32'h340618,
            {8'h0, refresh_cycle_time, avg_refresh_interval});
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        chk("reset mode", 32'h0, rd);
        end_of_test();
    end
endmodule
